// ==== common/dcssg_pkg.sv ====
// Package for the dual-channel safe stop gate: register map, codes and timing
package dcssg_pkg;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] DCSSG_OFS_CTRL   = 8'h00;
  localparam logic [7:0] DCSSG_OFS_STATUS = 8'h04;
  localparam logic [7:0] DCSSG_OFS_IRQ_ST = 8'h08;
  localparam logic [7:0] DCSSG_OFS_IRQ_MK = 8'h0C;
  localparam logic [7:0] DCSSG_OFS_IN3FN  = 8'h10;
  localparam logic [7:0] DCSSG_OFS_IN4FN  = 8'h14;
  localparam logic [7:0] DCSSG_OFS_IN3PL  = 8'h18;
  localparam logic [7:0] DCSSG_OFS_IN4PL  = 8'h1C;
  localparam logic [7:0] DCSSG_OFS_OUT1FN = 8'h20;
  localparam logic [7:0] DCSSG_OFS_OUT1PL = 8'h24;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CTRL_TRIP_LSB  = 0;  // safety_trip_select [1:0]
  localparam int CTRL_CLR_BIT   = 4;  // write one: clear latched trip
  localparam int CTRL_EXT_BIT   = 5;  // write one: raise external trip
  localparam int ST_ENABLE_BIT  = 0;
  localparam int ST_MON_BIT     = 1;
  localparam int ST_EMRG_BIT    = 2;
  localparam int ST_EXT_BIT     = 3;
  localparam int ST_CODE_LSB    = 4;  // reported fault code [7:4]
  localparam int ST_A_BIT       = 8;
  localparam int ST_B_BIT       = 9;
  localparam int ST_SSW_BIT     = 10;
  localparam int ST_MSW_BIT     = 11;
  localparam int ST_PWRON_BIT   = 12;
  localparam int IRQ_CUT_BIT    = 0;  // output cut event
  localparam int IRQ_EMRG_BIT   = 1;  // emergency trip raised
  localparam int IRQ_EXT_BIT    = 2;  // external trip raised
  localparam int IRQ_W          = 3;

  // ---------------------------------------------------------------------------
  // Setting codes
  // ---------------------------------------------------------------------------
  localparam logic [1:0] TRIP_SEL_HW   = 2'h0;
  localparam logic [1:0] TRIP_SEL_TRIP = 2'h1;
  localparam logic [7:0] FN_UNASSIGNED = 8'hFF;
  localparam logic [7:0] FN_SAFETY_A   = 8'd77;
  localparam logic [7:0] FN_SAFETY_B   = 8'd78;
  localparam logic [7:0] FN_MONITOR    = 8'd62;
  localparam logic [7:0] FN_IN3_RST    = 8'd18;
  localparam logic [7:0] FN_IN4_RST    = 8'd12;
  localparam logic [7:0] FN_OUT1_RST   = 8'd0;
  localparam logic [1:0] POL_NO        = 2'h0;
  localparam logic [1:0] POL_NC        = 2'h1;
  localparam logic [3:0] CODE_NONE     = 4'h0;
  localparam logic [3:0] CODE_EMRG     = 4'h1;
  localparam logic [3:0] CODE_EXT      = 4'h2;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ        = 125;
  localparam int CUTOFF_MAX_MS  = 10;
  localparam int CUTOFF_MAX_CYC = CUTOFF_MAX_MS * 1000 * CLK_MHZ;
  localparam int PWRON_WINDOW   = 16;  // cycles treated as power-on
  localparam int SYNC_LAT       = 3;   // synchroniser depth; pin to decision latency is 4 cycles

  typedef struct packed {
    logic a;
    logic b;
  } dcssg_chan_t;

  typedef struct packed {
    logic [7:0] in3_fn;
    logic [7:0] in4_fn;
    logic [1:0] in3_pl;
    logic [1:0] in4_pl;
    logic [7:0] out1_fn;
    logic [1:0] out1_pl;
  } dcssg_term_t;

endpackage : dcssg_pkg

// ==== src/dcssg_sync.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module dcssg_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Async pin and result
  input  wire logic async_i,
  output logic      sync_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Reset low: a channel counts as inactive until proven active
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        sync_o <= s3_q;
      end
    end
  end
endmodule : dcssg_sync

// ==== src/dcssg_top.sv ====
// Dual-channel safe stop gate with Wishbone register slave
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
module dcssg_top (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Safety channels and selector switches
  input  wire logic                 safety_input_a_i,
  input  wire logic                 safety_input_b_i,
  input  wire logic                 safety_switch_i,
  input  wire logic                 monitor_switch_i,
  input  wire logic                 safety_switch_prev_i,
  input  wire logic                 monitor_switch_prev_i,
  // Power stage and monitor
  output logic                      power_enable_o,
  output logic                      shutoff_monitor_output_o,
  output logic [3:0]                fault_code_o,
  output dcssg_pkg::dcssg_term_t    term_cfg_o,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // Interrupt
  output logic                      irq_o
);
  import dcssg_pkg::*;

  // ---------------------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------------------
  dcssg_chan_t ch;
  logic        ch_a_sync;
  logic        ch_b_sync;

  dcssg_sync u_sync_a (.clk_i(clk_i), .rst_i(rst_i), .async_i(safety_input_a_i),
                       .sync_o(ch_a_sync));
  dcssg_sync u_sync_b (.clk_i(clk_i), .rst_i(rst_i), .async_i(safety_input_b_i),
                       .sync_o(ch_b_sync));
  assign ch = '{a: ch_a_sync, b: ch_b_sync};

  // ---------------------------------------------------------------------------
  // Switch capture at reset release
  // ---------------------------------------------------------------------------
  // Switches are only legal to move unpowered, so one sample suffices
  logic       cap_pending_q;
  logic       ssw_q;
  logic       msw_q;
  logic       ssw_prev_q;
  logic       msw_prev_q;
  logic [4:0] pwron_cnt_q;
  logic       pwron_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_pending_q <= 1'b1;
      ssw_q         <= 1'b0;
      msw_q         <= 1'b0;
      ssw_prev_q    <= 1'b0;
      msw_prev_q    <= 1'b0;
    end else if (cap_pending_q) begin
      cap_pending_q <= 1'b0;
      ssw_q         <= safety_switch_i;
      msw_q         <= monitor_switch_i;
      ssw_prev_q    <= safety_switch_prev_i;
      msw_prev_q    <= monitor_switch_prev_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwron_cnt_q <= 5'h0_0;
      pwron_q     <= 1'b1;
    end else if (pwron_q) begin
      pwron_cnt_q <= pwron_cnt_q + 5'h0_1;
      pwron_q     <= (pwron_cnt_q != 5'(PWRON_WINDOW - 1));
    end
  end

  // ---------------------------------------------------------------------------
  // Register bus decode
  // ---------------------------------------------------------------------------
  logic        wb_req;
  logic        wb_wr;
  logic        wr_ctrl;
  logic        wr_irq_st;
  logic        wr_irq_mk;
  logic        cfg_wr_ok;
  logic        mon_wr_ok;
  logic [31:0] rd_mux;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr == ofs);
  endfunction : hit

  assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr     = wb_req & wb_we_i & wb_sel_i[0];
  assign wr_ctrl   = wb_wr & hit(wb_adr_i, DCSSG_OFS_CTRL);
  assign wr_irq_st = wb_wr & hit(wb_adr_i, DCSSG_OFS_IRQ_ST);
  assign wr_irq_mk = wb_wr & hit(wb_adr_i, DCSSG_OFS_IRQ_MK);
  assign cfg_wr_ok = ~cap_pending_q & ~ssw_q;
  assign mon_wr_ok = ~cap_pending_q & ~msw_q;

  // ---------------------------------------------------------------------------
  // Terminal settings
  // ---------------------------------------------------------------------------
  dcssg_term_t term_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      term_q <= '{FN_IN3_RST, FN_IN4_RST, POL_NO, POL_NO, FN_OUT1_RST, POL_NO};
    end else if (cap_pending_q) begin
      if (safety_switch_i) begin
        term_q.in3_fn <= FN_SAFETY_A;
        term_q.in4_fn <= FN_SAFETY_B;
        term_q.in3_pl <= POL_NC;
        term_q.in4_pl <= POL_NC;
      end else if (safety_switch_prev_i) begin
        term_q.in3_fn <= FN_UNASSIGNED;
        term_q.in4_fn <= FN_UNASSIGNED;
        term_q.in3_pl <= POL_NC;
        term_q.in4_pl <= POL_NC;
      end
      if (monitor_switch_i) begin
        term_q.out1_fn <= FN_MONITOR;
        term_q.out1_pl <= POL_NO;
      end else if (monitor_switch_prev_i) begin
        term_q.out1_fn <= FN_UNASSIGNED;
        term_q.out1_pl <= POL_NC;
      end
    end else begin
      if (wb_wr && cfg_wr_ok && hit(wb_adr_i, DCSSG_OFS_IN3FN)) term_q.in3_fn <= wb_dat_i[7:0];
      if (wb_wr && cfg_wr_ok && hit(wb_adr_i, DCSSG_OFS_IN4FN)) term_q.in4_fn <= wb_dat_i[7:0];
      if (wb_wr && cfg_wr_ok && hit(wb_adr_i, DCSSG_OFS_IN3PL)) term_q.in3_pl <= wb_dat_i[1:0];
      if (wb_wr && cfg_wr_ok && hit(wb_adr_i, DCSSG_OFS_IN4PL)) term_q.in4_pl <= wb_dat_i[1:0];
      if (wb_wr && mon_wr_ok && hit(wb_adr_i, DCSSG_OFS_OUT1FN)) term_q.out1_fn <= wb_dat_i[7:0];
      if (wb_wr && mon_wr_ok && hit(wb_adr_i, DCSSG_OFS_OUT1PL)) term_q.out1_pl <= wb_dat_i[1:0];
    end
  end

  assign term_cfg_o = term_q;

  // ---------------------------------------------------------------------------
  // Gate, trips and fault reporting
  // ---------------------------------------------------------------------------
  logic [1:0] trip_sel_q;
  logic       emrg_q;
  logic       ext_q;
  logic       both_on;
  logic       both_off;
  logic       emrg_set;
  logic       ext_set;
  logic       clr_req;
  logic [3:0] code_d;

  assign both_on  = ch.a & ch.b;
  assign both_off = ~ch.a & ~ch.b;
  assign clr_req  = wr_ctrl & wb_dat_i[CTRL_CLR_BIT];
  assign emrg_set = ~both_on & (trip_sel_q == TRIP_SEL_TRIP);
  assign ext_set  = wr_ctrl & wb_dat_i[CTRL_EXT_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trip_sel_q <= TRIP_SEL_HW;
      emrg_q     <= 1'b0;
      ext_q      <= 1'b0;
    end else begin
      if (wr_ctrl) trip_sel_q <= wb_dat_i[CTRL_TRIP_LSB +: 2];
      // Set wins over clear; latch holds after channels return
      emrg_q <= emrg_set | (emrg_q & ~clr_req);
      ext_q  <= ext_set | (ext_q & ~clr_req);
    end
  end

  // Emergency wins, unless still inside the power-on window
  assign code_d = (emrg_q && ext_q) ? (pwron_q ? CODE_EXT : CODE_EMRG) :
                  emrg_q            ? CODE_EMRG :
                  ext_q             ? CODE_EXT  : CODE_NONE;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_enable_o           <= 1'b0;
      shutoff_monitor_output_o <= 1'b0;
      fault_code_o             <= CODE_NONE;
    end else begin
      // One cycle from decision to cut, far below the limit
      power_enable_o           <= both_on & ~emrg_q & ~ext_q & ~emrg_set;
      shutoff_monitor_output_o <= both_off;
      fault_code_o             <= code_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_mk_q;
  logic [IRQ_W-1:0] irq_ev;
  logic             en_prev_q;

  assign irq_ev[IRQ_CUT_BIT]  = en_prev_q & ~power_enable_o;
  assign irq_ev[IRQ_EMRG_BIT] = emrg_set & ~emrg_q;
  assign irq_ev[IRQ_EXT_BIT]  = ext_set & ~ext_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_q  <= '0;
      irq_mk_q  <= '0;
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= power_enable_o;
      irq_st_q  <= irq_ev | (irq_st_q & ~(wr_irq_st ? wb_dat_i[IRQ_W-1:0] : '0));
      if (wr_irq_mk) irq_mk_q <= wb_dat_i[IRQ_W-1:0];
    end
  end

  assign irq_o = |(irq_st_q & irq_mk_q);

  // ---------------------------------------------------------------------------
  // Read mux and acknowledge
  // ---------------------------------------------------------------------------
  logic [31:0] status_w;

  assign status_w = {19'h0_0000, pwron_q, msw_q, ssw_q, ch.b, ch.a,
                     fault_code_o, ext_q, emrg_q, shutoff_monitor_output_o,
                     power_enable_o};
  assign rd_mux = hit(wb_adr_i, DCSSG_OFS_CTRL)   ? {30'h0, trip_sel_q} :
                  hit(wb_adr_i, DCSSG_OFS_STATUS) ? status_w :
                  hit(wb_adr_i, DCSSG_OFS_IRQ_ST) ? {29'h0, irq_st_q} :
                  hit(wb_adr_i, DCSSG_OFS_IRQ_MK) ? {29'h0, irq_mk_q} :
                  hit(wb_adr_i, DCSSG_OFS_IN3FN)  ? {24'h0, term_q.in3_fn} :
                  hit(wb_adr_i, DCSSG_OFS_IN4FN)  ? {24'h0, term_q.in4_fn} :
                  hit(wb_adr_i, DCSSG_OFS_IN3PL)  ? {30'h0, term_q.in3_pl} :
                  hit(wb_adr_i, DCSSG_OFS_IN4PL)  ? {30'h0, term_q.in4_pl} :
                  hit(wb_adr_i, DCSSG_OFS_OUT1FN) ? {24'h0, term_q.out1_fn} :
                  hit(wb_adr_i, DCSSG_OFS_OUT1PL) ? {30'h0, term_q.out1_pl} :
                  32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) wb_dat_o <= rd_mux;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_chan_lost;
    !(ch.a && ch.b);
  endsequence

  property p_enable_needs_both;
    @(posedge clk_i) disable iff (rst_i) power_enable_o |-> $past(ch.a) && $past(ch.b);
  endproperty
  a_enable_needs_both: assert property (p_enable_needs_both)
    else $error("power enabled without both channels");
  property p_cut_on_loss;
    @(posedge clk_i) disable iff (rst_i) s_chan_lost |=> !power_enable_o;
  endproperty
  a_cut_on_loss: assert property (p_cut_on_loss)
    else $error("output not cut after channel loss");
  property p_emrg_priority;
    @(posedge clk_i) disable iff (rst_i)
      (emrg_q && ext_q && !pwron_q) |=> (fault_code_o == CODE_EMRG);
  endproperty
  a_emrg_priority: assert property (p_emrg_priority)
    else $error("emergency fault not given priority");
  property p_hw_mode_no_trip;
    @(posedge clk_i) disable iff (rst_i)
      (trip_sel_q == TRIP_SEL_HW && !emrg_q) |=> !emrg_q;
  endproperty
  a_hw_mode_no_trip: assert property (p_hw_mode_no_trip)
    else $error("trip raised in hardware-only mode");
  property p_trip_mode_trips;
    @(posedge clk_i) disable iff (rst_i)
      (trip_sel_q == TRIP_SEL_TRIP && !(ch.a && ch.b)) |=> emrg_q;
  endproperty
  a_trip_mode_trips: assert property (p_trip_mode_trips)
    else $error("trip not raised on channel loss");
  property p_safety_forced;
    @(posedge clk_i) disable iff (rst_i)
      (!cap_pending_q && ssw_q) |-> term_q.in3_fn == FN_SAFETY_A && term_q.in4_fn == FN_SAFETY_B
                                    && term_q.in3_pl == POL_NC && term_q.in4_pl == POL_NC;
  endproperty
  a_safety_forced: assert property (p_safety_forced)
    else $error("safety terminal settings not forced");
  property p_monitor_forced;
    @(posedge clk_i) disable iff (rst_i)
      (!cap_pending_q && msw_q) |-> term_q.out1_fn == FN_MONITOR && term_q.out1_pl == POL_NO;
  endproperty
  a_monitor_forced: assert property (p_monitor_forced)
    else $error("monitor terminal settings not forced");
  property p_monitor_both_off;
    @(posedge clk_i) disable iff (rst_i)
      shutoff_monitor_output_o |-> !$past(ch.a) && !$past(ch.b) && !power_enable_o;
  endproperty
  a_monitor_both_off: assert property (p_monitor_both_off)
    else $error("monitor high with a channel active");
  property p_trip_latched;
    @(posedge clk_i) disable iff (rst_i) (emrg_q && !clr_req) |=> emrg_q && !power_enable_o;
  endproperty
  a_trip_latched: assert property (p_trip_latched)
    else $error("emergency trip released without clear");

endmodule : dcssg_top

// ==== verification/dcssg_relay_model.sv ====
// Behavioural model of the external two-channel safety relay
`timescale 1ns/100ps
module dcssg_relay_model (
  // Clock
  input  wire logic clk_i,
  // Commands from the bench
  input  wire logic stop_i,
  input  wire logic open_a_i,
  // Safety channels, high = current flowing
  output logic      safety_input_a_o,
  output logic      safety_input_b_o
);
  // One demand opens both contacts; a lone open channel only when commanded
  always_ff @(posedge clk_i) begin
    safety_input_a_o <= !(stop_i || open_a_i);
    safety_input_b_o <= !stop_i;
  end
endmodule : dcssg_relay_model

// ==== verification/testbench.sv ====
// Self-checking bench for the dual-channel safe stop gate
`timescale 1ns/100ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_fail++; \
  $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module testbench;
  import dcssg_pkg::*;
  typedef struct packed { logic [31:0] exp; logic [31:0] msk; } dcssg_note_t;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        sw_s  = 1'b1;
  logic        sw_m  = 1'b1;
  logic        sw_sp = 1'b0;
  logic        sw_mp = 1'b0;
  logic        stop  = 1'b0;
  logic        open_a = 1'b0;
  logic        ch_a;
  logic        ch_b;
  logic        enable;
  logic        mon;
  logic [3:0]  fcode;
  dcssg_term_t term;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we  = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_rd;
  logic        wb_ack;
  logic        irq;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc_count = 0;
  logic [31:0] rnd;
  dcssg_note_t notes[$];
  dcssg_note_t nt;

  always #4 clk_i = ~clk_i;

  dcssg_relay_model relay (.clk_i(clk_i), .stop_i(stop), .open_a_i(open_a),
    .safety_input_a_o(ch_a), .safety_input_b_o(ch_b));

  dcssg_top dut (.clk_i(clk_i), .rst_i(rst_i), .safety_input_a_i(ch_a),
    .safety_input_b_i(ch_b), .safety_switch_i(sw_s), .monitor_switch_i(sw_m),
    .safety_switch_prev_i(sw_sp), .monitor_switch_prev_i(sw_mp),
    .power_enable_o(enable), .shutoff_monitor_output_o(mon), .fault_code_o(fcode),
    .term_cfg_o(term), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd),
    .wb_ack_o(wb_ack), .irq_o(irq));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // Request held until the ack edge, then released for one idle cycle
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_dat <= d;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask : wb_cycle

  task automatic wb_read(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back({e, m});
    wb_cycle(1'b0, a, 32'h0000_0000);
  endtask : wb_read

  // Bounded wait; the caller compares afterwards
  task automatic wait_en(input logic v);
    for (int i = 0; i < 16 && enable !== v; i++) @(posedge clk_i);
  endtask : wait_en

  task automatic do_reset(input int settle);
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (settle) @(posedge clk_i);
  endtask : do_reset

  // ---------------------------------------------------------------------------
  // Read-data checker and timeout
  // ---------------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (wb_ack === 1'b1 && wb_we === 1'b0) begin
      if (notes.size() == 0) begin
        n_fail++;
        $display("Error at %0t: read data with no note", $time);
      end else begin
        nt = notes.pop_front();
        `CHK(wb_rd & nt.msk, nt.exp)
      end
    end
  end

  always @(posedge clk_i) begin
    cyc_count++;
    if (cyc_count == 6000) begin
      n_fail++;
      $display("Error at %0t: timeout", $time);
      final_report();
    end
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    void'($urandom(32'h2fd8_a42e));
    do_reset(20);
    `CHK(term.in3_fn, FN_SAFETY_A)
    `CHK(term.in4_fn, FN_SAFETY_B)
    `CHK({term.in3_pl, term.in4_pl}, {POL_NC, POL_NC})
    `CHK({term.out1_fn, term.out1_pl}, {FN_MONITOR, POL_NO})
    rnd = $urandom();
    wb_cycle(1'b1, DCSSG_OFS_IN3FN, rnd);
    wb_cycle(1'b1, DCSSG_OFS_IN4PL, 32'h0000_0000);
    wb_cycle(1'b1, DCSSG_OFS_OUT1FN, rnd);
    wb_read(DCSSG_OFS_IN3FN, {24'h0, FN_SAFETY_A}, 32'h0000_00FF);
    wb_read(DCSSG_OFS_IN4PL, {30'h0, POL_NC}, 32'h0000_0003);
    wb_read(DCSSG_OFS_OUT1FN, {24'h0, FN_MONITOR}, 32'h0000_00FF);
    wb_read(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
    $display("Test locked settings done");

    wb_cycle(1'b1, DCSSG_OFS_CTRL, {30'h0, TRIP_SEL_HW});
    wait_en(1'b1);
    `CHK(enable, 1'b1)
    open_a <= 1'b1;
    wait_en(1'b0);
    `CHK(enable, 1'b0)
    repeat (8) @(posedge clk_i);
    `CHK(mon, 1'b0)
    `CHK(fcode, CODE_NONE)
    stop <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK(mon, 1'b1)
    stop <= 1'b0;
    open_a <= 1'b0;
    wait_en(1'b1);
    `CHK({enable, mon}, 2'b10)
    $display("Test hardware cutoff done");

    wb_cycle(1'b1, DCSSG_OFS_IRQ_MK, 32'h0000_0001 << IRQ_CUT_BIT);
    repeat (2) @(posedge clk_i);
    `CHK(irq, 1'b1)
    wb_cycle(1'b1, DCSSG_OFS_IRQ_ST, 32'h0000_0001 << IRQ_CUT_BIT);
    wb_read(DCSSG_OFS_IRQ_ST, 32'h0000_0000, 32'h0000_0001);
    `CHK(irq, 1'b0)
    $display("Test interrupt done");

    wb_cycle(1'b1, DCSSG_OFS_CTRL, {30'h0, TRIP_SEL_TRIP});
    stop <= 1'b1;
    wait_en(1'b0);
    `CHK(enable, 1'b0)
    stop <= 1'b0;
    repeat (12) @(posedge clk_i);
    `CHK(enable, 1'b0)
    `CHK(fcode, CODE_EMRG)
    wb_cycle(1'b1, DCSSG_OFS_CTRL, 32'h0000_0021);
    repeat (2) @(posedge clk_i);
    `CHK(fcode, CODE_EMRG)
    wb_read(DCSSG_OFS_STATUS, 32'h0000_001C, 32'h0000_00FC);
    wb_cycle(1'b1, DCSSG_OFS_CTRL, 32'h0000_0011);
    wait_en(1'b1);
    `CHK(enable, 1'b1)
    $display("Test latched trip done");

    // Channels held off across a mid-run reset; both faults raised inside power-on
    stop <= 1'b1;
    do_reset(2);
    wb_cycle(1'b1, DCSSG_OFS_CTRL, 32'h0000_0021);
    repeat (2) @(posedge clk_i);
    `CHK(fcode, CODE_EXT)
    repeat (16) @(posedge clk_i);
    `CHK(fcode, CODE_EMRG)
    stop <= 1'b0;
    $display("Test power-on priority done");

    // Switches move only while held in reset
    sw_s  <= 1'b0;
    sw_m  <= 1'b0;
    sw_sp <= 1'b1;
    sw_mp <= 1'b1;
    do_reset(20);
    `CHK({term.in3_fn, term.in4_fn}, {FN_UNASSIGNED, FN_UNASSIGNED})
    `CHK({term.in3_pl, term.in4_pl}, {POL_NC, POL_NC})
    `CHK({term.out1_fn, term.out1_pl}, {FN_UNASSIGNED, POL_NC})
    wb_cycle(1'b1, DCSSG_OFS_IN3FN, rnd);
    wb_read(DCSSG_OFS_IN3FN, {24'h0, rnd[7:0]}, 32'h0000_00FF);
    $display("Test switch release done");
    final_report();
  end
endmodule : testbench
